// >>> logic/effective_address_generator.sv
// effective address generator for memory reference instructions, types I to VI
// Overview of operation
// (RULE_01) direct address uses bits 5-17 in bank mode, bits 6-17 in page mode
// (RULE_02) bit 4 set: read the operand location, fetched word becomes the address
// (RULE_03) direct addresses combine with the running program's bank, not bank zero
// (RULE_04) indirect to cells 10-17 octal: read, add one, write back, use result
// (RULE_05) no increment on direct references to the auto-increment cells
// (RULE_06) auto-increment cells are absolute, whatever bank or page runs
// (RULE_07) 18-bit signed index, 18-bit counter, 17-bit effective addresses
// (RULE_08) indexing only in page mode with bit 5; no extra memory cycle
// (RULE_09) indexed address is upper counter bits and field plus the index
// (RULE_10) index added as full 18-bit two's complement, negative reaches below
// (RULE_11) indexed addressing reaches every address 000000 to 377777 octal
// (RULE_12) page mode with bits 4 and 5: fetch pointer, then add the index
// (RULE_13) indirect indexed pointer is counter bits 1-5 joined to bits 6-17
// (RULE_14) index addition is always the last step, applied to the fetched word
// (RULE_15) page mode, bits 4 and 5, field 10-17 octal selects auto-increment indexed
// (RULE_16) auto-increment indexed reads, increments, writes back, uses new pointer
// (RULE_17) auto-increment indexed adds index bits 0-17 to the pointer
// (RULE_18) bank mode: bit 5 is address, never an index request
//
// The implementer's own choices: the address map and strobed register access.
`timescale 1ns/1ns
module effective_address_generator #(
  parameter int WORD_W = ea_gen_pkg::WORD_W,
  parameter int ADDR_W = ea_gen_pkg::ADDR_W
) (
  input wire logic i_clock,
  input wire logic i_srst,
  // register port
  input wire logic [7:0] i_reg_addr,
  input wire logic [17:0] i_reg_wdata,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  output logic [17:0] o_reg_rdata,
  // instruction in
  input wire logic i_start,
  input wire logic [17:0] i_instruction,
  output logic o_busy,
  output logic o_done,
  output logic [16:0] o_effective_address,
  output logic [2:0] o_addr_type,
  // memory cycles toward the mapping unit
  output logic o_mem_req,
  output logic o_mem_we,
  output logic [16:0] o_mem_addr,
  output logic [17:0] o_mem_wdata,
  input wire logic i_mem_ack,
  input wire logic [17:0] i_mem_rdata
);
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_FETCH = 2'b01,
    ST_STORE = 2'b10
  } state_t;

  // the datapath is fixed at the documented word and address sizes
  if (WORD_W != 18 || ADDR_W != 17) begin : g_width_check
    $error("effective_address_generator supports only 18-bit words and 17-bit addresses");
  end

  logic page_mode;
  logic [17:0] index_value;
  logic [17:0] counter;
  state_t state_ff;
  state_t nxt_state;
  logic [2:0] type_ff;
  logic [2:0] nxt_type;
  logic post_index_ff;
  logic [17:0] xr_snap_ff;
  logic [16:0] ea_ff;
  logic done_ff;
  logic mem_req_ff;
  logic mem_we_ff;
  logic [16:0] mem_addr_ff;
  logic [17:0] mem_wdata_ff;
  logic ind_bit;
  logic idx_req;
  logic [12:0] field;
  logic auto_cell;
  logic [16:0] local_addr;
  logic [16:0] ptr_addr;
  logic [16:0] direct_ea;
  logic [17:0] incremented;
  logic start_ok;
  logic ack_fetch;
  logic ack_store;

  ////////////////////////////////////////////////////////////////////////////
  // software registers
  ea_gen_regs u_regs (
    .i_clock(i_clock),
    .i_srst(i_srst),
    .i_reg_addr(i_reg_addr),
    .i_reg_wdata(i_reg_wdata),
    .i_reg_wr(i_reg_wr),
    .i_reg_rd(i_reg_rd),
    .o_reg_rdata(o_reg_rdata),
    .i_busy(o_busy),
    .i_addr_type(type_ff),
    .i_effective_address(ea_ff),
    .o_page_mode(page_mode),
    .o_index_value(index_value),
    .o_counter(counter)
  );

  // two's complement index add, wrapped to the 17-bit address space
  function automatic logic [16:0] add_index(input logic [16:0] base, input logic [17:0] xr);
    logic [17:0] sum;
    sum = {1'b0, base} + xr; // RULE_10
    return sum[16:0]; // RULE_11
  endfunction : add_index

  ////////////////////////////////////////////////////////////////////////////
  // instruction decode
  assign ind_bit = i_instruction[ea_gen_pkg::IND_POS]; // RULE_02
  assign idx_req = page_mode && i_instruction[ea_gen_pkg::IDX_POS]; // RULE_08 RULE_18
  // bank mode keeps bit 5 in the field, page mode drops it
  assign field = page_mode ? {1'b0, i_instruction[ea_gen_pkg::PAGE_FIELD_W-1:0]}
                           : i_instruction[ea_gen_pkg::BANK_FIELD_W-1:0]; // RULE_01 RULE_18
  // the cell test looks at bit 4 and the field, never the counter, so it fires from any bank
  assign auto_cell = ind_bit && field >= ea_gen_pkg::AUTO_LO && field <= ea_gen_pkg::AUTO_HI; // RULE_04 RULE_06 RULE_15

  // field joined with the running program's bank or page
  always_comb begin
    if (page_mode) begin
      local_addr = {counter[ea_gen_pkg::UPPER_HI:ea_gen_pkg::UPPER_LO], field[11:0]}; // RULE_09 RULE_13
    end else begin
      local_addr = {counter[ea_gen_pkg::UPPER_HI:ea_gen_pkg::BANK_LO], field}; // RULE_03
    end
  end

  // auto-increment cells are absolute, other pointers live in the current bank or page
  assign ptr_addr = auto_cell ? {4'h0, field} : local_addr; // RULE_06
  // no memory cycle for types I and IV
  assign direct_ea = idx_req ? add_index(local_addr, index_value) : local_addr; // RULE_08 RULE_09

  // pointer increment, full word so the written value keeps bit 0
  assign incremented = i_mem_rdata + 18'h00001;

  always_comb begin
    if (!ind_bit) begin
      nxt_type = idx_req ? ea_gen_pkg::TYPE_INDEXED : ea_gen_pkg::TYPE_DIRECT;
    end else if (auto_cell) begin
      nxt_type = idx_req ? ea_gen_pkg::TYPE_AUTO_INDEXED : ea_gen_pkg::TYPE_AUTO;
    end else begin
      nxt_type = idx_req ? ea_gen_pkg::TYPE_IND_INDEXED : ea_gen_pkg::TYPE_INDIRECT;
    end
  end

  assign start_ok = i_start && state_ff == ST_IDLE; // starts while busy are dropped
  assign ack_fetch = state_ff == ST_FETCH && i_mem_ack;
  assign ack_store = state_ff == ST_STORE && i_mem_ack;

  ////////////////////////////////////////////////////////////////////////////
  // sequencer
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      ST_IDLE: begin
        if (start_ok && ind_bit) begin
          nxt_state = ST_FETCH; // RULE_02 RULE_12
        end
      end
      ST_FETCH: begin
        if (i_mem_ack) begin
          nxt_state = (type_ff == ea_gen_pkg::TYPE_AUTO || type_ff == ea_gen_pkg::TYPE_AUTO_INDEXED)
                      ? ST_STORE : ST_IDLE; // RULE_04 RULE_16
        end
      end
      ST_STORE: begin
        if (i_mem_ack) begin
          nxt_state = ST_IDLE;
        end
      end
      default: nxt_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      state_ff <= ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // instruction context captured at start so later register writes cannot disturb it
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      type_ff <= 3'h0;
      post_index_ff <= 1'b0;
      xr_snap_ff <= 18'h00000;
    end else if (start_ok) begin
      type_ff <= nxt_type;
      post_index_ff <= idx_req;
      xr_snap_ff <= index_value;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // memory requests, held until acknowledged
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      mem_req_ff <= 1'b0;
      mem_we_ff <= 1'b0;
      mem_addr_ff <= 17'h00000;
      mem_wdata_ff <= 18'h00000;
    end else if (start_ok && ind_bit) begin
      mem_req_ff <= 1'b1; // RULE_02
      mem_we_ff <= 1'b0;
      mem_addr_ff <= ptr_addr; // RULE_13
    end else if (ack_fetch && (type_ff == ea_gen_pkg::TYPE_AUTO || type_ff == ea_gen_pkg::TYPE_AUTO_INDEXED)) begin
      mem_req_ff <= 1'b1;
      mem_we_ff <= 1'b1; // RULE_04 RULE_16
      mem_wdata_ff <= incremented;
    end else if (i_mem_ack) begin
      mem_req_ff <= 1'b0;
      mem_we_ff <= 1'b0;
    end
  end

  // effective address and completion pulse
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      ea_ff <= 17'h00000;
      done_ff <= 1'b0;
    end else begin
      done_ff <= 1'b0;
      if (start_ok && !ind_bit) begin
        ea_ff <= direct_ea; // RULE_01 RULE_03 RULE_05 RULE_08
        done_ff <= 1'b1;
      end else if (ack_fetch && (type_ff == ea_gen_pkg::TYPE_AUTO || type_ff == ea_gen_pkg::TYPE_AUTO_INDEXED)) begin
        // incremented value is the pointer; index applied last
        ea_ff <= post_index_ff ? add_index(incremented[16:0], xr_snap_ff) : incremented[16:0]; // RULE_16 RULE_17
      end else if (ack_fetch) begin
        ea_ff <= post_index_ff ? add_index(i_mem_rdata[16:0], xr_snap_ff) : i_mem_rdata[16:0]; // RULE_02 RULE_14
        done_ff <= 1'b1;
      end else if (ack_store) begin
        done_ff <= 1'b1; // address already formed; finish once the write-back lands
      end
    end
  end

  assign o_busy = state_ff != ST_IDLE;
  assign o_done = done_ff;
  assign o_effective_address = ea_ff;
  assign o_addr_type = type_ff;
  assign o_mem_req = mem_req_ff;
  assign o_mem_we = mem_we_ff;
  assign o_mem_addr = mem_addr_ff;
  assign o_mem_wdata = mem_wdata_ff;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  logic [16:0] past_ptr_q;
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      past_ptr_q <= 17'h00000;
    end else if (start_ok) begin
      past_ptr_q <= ptr_addr;
    end
  end

  direct_no_mem_a: assert property (@(posedge i_clock) disable iff (i_srst) // RULE_08
    start_ok && !ind_bit |=> o_done && !o_mem_req && !o_busy)
    else $error("direct or indexed reference used a memory cycle");

  indirect_reads_a: assert property (@(posedge i_clock) disable iff (i_srst) // RULE_02
    start_ok && ind_bit |=> o_mem_req && !o_mem_we && o_mem_addr == past_ptr_q && !o_done)
    else $error("indirect reference did not issue a read");

  bank_field_a: assert property (@(posedge i_clock) disable iff (i_srst) // RULE_01
    start_ok && !ind_bit && !page_mode |=>
      o_effective_address[12:0] == $past(i_instruction[12:0]))
    else $error("bank mode direct address field wrong");

  bank_current_a: assert property (@(posedge i_clock) disable iff (i_srst) // RULE_03
    start_ok && !ind_bit && !page_mode |=> o_effective_address[16:13] == $past(counter[16:13]))
    else $error("direct address not in running bank");

  no_index_bank_a: assert property (@(posedge i_clock) disable iff (i_srst) // RULE_18
    start_ok && !page_mode |=> o_addr_type != ea_gen_pkg::TYPE_INDEXED
      && o_addr_type != ea_gen_pkg::TYPE_IND_INDEXED && o_addr_type != ea_gen_pkg::TYPE_AUTO_INDEXED)
    else $error("bank mode decoded an index request");

  indexed_sum_a: assert property (@(posedge i_clock) disable iff (i_srst) // RULE_09
    start_ok && !ind_bit && page_mode && i_instruction[12] |=> o_effective_address ==
      17'(({1'b0, $past(counter[16:12]), $past(i_instruction[11:0])} + $past(index_value))))
    else $error("indexed effective address wrong");

  auto_abs_a: assert property (@(posedge i_clock) disable iff (i_srst) // RULE_06
    start_ok && auto_cell |=> o_mem_addr[16:4] == 13'h0000 && o_mem_addr[3])
    else $error("auto-increment cell not absolute");

  auto_write_a: assert property (@(posedge i_clock) disable iff (i_srst) // RULE_04
    ack_fetch && (type_ff == ea_gen_pkg::TYPE_AUTO) |=>
      o_mem_we && o_mem_req && o_mem_wdata == $past(i_mem_rdata) + 18'h00001
      && o_effective_address == 17'($past(i_mem_rdata) + 18'h00001))
    else $error("auto-increment write-back wrong");

  auto_direct_a: assert property (@(posedge i_clock) disable iff (i_srst) // RULE_05
    start_ok && !ind_bit |=> !o_mem_we [*2])
    else $error("direct reference incremented a cell");

  post_index_a: assert property (@(posedge i_clock) disable iff (i_srst) // RULE_14
    ack_fetch && type_ff == ea_gen_pkg::TYPE_IND_INDEXED |=>
      o_done && o_effective_address == 17'({1'b0, $past(i_mem_rdata[16:0])} + $past(xr_snap_ff)))
    else $error("post-indexed address wrong");

  auto_index_a: assert property (@(posedge i_clock) disable iff (i_srst) // RULE_17
    ack_fetch && type_ff == ea_gen_pkg::TYPE_AUTO_INDEXED |=>
      o_effective_address == 17'({1'b0, 17'($past(i_mem_rdata) + 18'h00001)} + $past(xr_snap_ff)))
    else $error("auto-increment indexed address wrong");

  auto_idx_sel_a: assert property (@(posedge i_clock) disable iff (i_srst) // RULE_15
    start_ok && page_mode && i_instruction[13] && i_instruction[12] && auto_cell
      |=> o_addr_type == ea_gen_pkg::TYPE_AUTO_INDEXED)
    else $error("auto-increment indexed not selected");

  auto_done_a: assert property (@(posedge i_clock) disable iff (i_srst) // RULE_16
    ack_store |=> o_done && !o_mem_req && !o_busy)
    else $error("write-back did not complete the reference");

  // the request and all that qualifies it stand until memory answers
  req_hold_a: assert property (@(posedge i_clock) disable iff (i_srst) // RULE_02
    o_mem_req && !i_mem_ack |=> o_mem_req && $stable(o_mem_we) && $stable(o_mem_addr)
      && $stable(o_mem_wdata))
    else $error("memory request changed before acknowledge");

  page_ptr_a: assert property (@(posedge i_clock) disable iff (i_srst) // RULE_13
    start_ok && ind_bit && !auto_cell && page_mode |=>
      o_mem_addr == {$past(counter[16:12]), $past(i_instruction[11:0])})
    else $error("page mode pointer location wrong");

  ind_idx_sel_a: assert property (@(posedge i_clock) disable iff (i_srst) // RULE_12
    start_ok && page_mode && i_instruction[13] && i_instruction[12] && !auto_cell
      |=> o_addr_type == ea_gen_pkg::TYPE_IND_INDEXED && o_mem_req && !o_mem_we)
    else $error("indirect indexed not selected");

  // a negative index is a subtraction of its magnitude, so this cross-checks the adder
  neg_index_a: assert property (@(posedge i_clock) disable iff (i_srst) // RULE_10
    start_ok && !ind_bit && page_mode && i_instruction[12] && index_value[17] |=>
      o_effective_address == 17'({$past(counter[16:12]), $past(i_instruction[11:0])} - 17'(-$past(index_value))))
    else $error("negative index did not reach below the running page");

  cov_indexed_c: cover property (@(posedge i_clock) disable iff (i_srst)
    o_done && o_addr_type == ea_gen_pkg::TYPE_INDEXED && index_value[17]);
  cov_ind_idx_c: cover property (@(posedge i_clock) disable iff (i_srst)
    o_done && o_addr_type == ea_gen_pkg::TYPE_IND_INDEXED);
  cov_auto_idx_c: cover property (@(posedge i_clock) disable iff (i_srst)
    ack_store ##1 o_done && o_addr_type == ea_gen_pkg::TYPE_AUTO_INDEXED);
  cov_auto_c: cover property (@(posedge i_clock) disable iff (i_srst)
    o_done && o_addr_type == ea_gen_pkg::TYPE_AUTO);
  cov_bank_ind_c: cover property (@(posedge i_clock) disable iff (i_srst)
    o_done && o_addr_type == ea_gen_pkg::TYPE_INDIRECT && !page_mode);
endmodule : effective_address_generator

// >>> logic/ea_gen_pkg.sv
// constants shared by the effective address generator and its register file
package ea_gen_pkg;
  localparam int WORD_W = 18;
  localparam int ADDR_W = 17;
  localparam int REG_AW = 8;
  // register byte offsets
  localparam logic [7:0] OFS_CONTROL = 8'h00;
  localparam logic [7:0] OFS_INDEX = 8'h04;
  localparam logic [7:0] OFS_COUNTER = 8'h08;
  localparam logic [7:0] OFS_EFFECTIVE = 8'h0C;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  // control register fields and reset values
  localparam int CTRL_PAGE_BIT = 0;
  localparam logic CTRL_PAGE_RST = 1'b0;
  localparam logic [17:0] INDEX_RST = 18'h00000;
  localparam logic [17:0] COUNTER_RST = 18'h00000;
  // instruction fields, bit 0 of the word being the most significant (vector bit 17)
  localparam int IND_POS = 13;
  localparam int IDX_POS = 12;
  localparam int BANK_FIELD_W = 13;
  localparam int PAGE_FIELD_W = 12;
  // counter_upper_bits are counter bits 1..5 (vector 16:12)
  localparam int UPPER_HI = 16;
  localparam int UPPER_LO = 12;
  localparam int BANK_LO = 13;
  // auto-increment cells, octal 10 through 17
  localparam logic [12:0] AUTO_LO = 13'h0008;
  localparam logic [12:0] AUTO_HI = 13'h000F;
  // addressing types reported in status
  localparam logic [2:0] TYPE_DIRECT = 3'h1;
  localparam logic [2:0] TYPE_INDIRECT = 3'h2;
  localparam logic [2:0] TYPE_AUTO = 3'h3;
  localparam logic [2:0] TYPE_INDEXED = 3'h4;
  localparam logic [2:0] TYPE_IND_INDEXED = 3'h5;
  localparam logic [2:0] TYPE_AUTO_INDEXED = 3'h6;
endpackage : ea_gen_pkg

// >>> logic/ea_gen_regs.sv
// software register file of the effective address generator
`timescale 1ns/1ns
module ea_gen_regs (
  input wire logic i_clock,
  input wire logic i_srst,
  input wire logic [7:0] i_reg_addr,
  input wire logic [17:0] i_reg_wdata,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  output logic [17:0] o_reg_rdata,
  input wire logic i_busy,
  input wire logic [2:0] i_addr_type,
  input wire logic [16:0] i_effective_address,
  output logic o_page_mode,
  output logic [17:0] o_index_value,
  output logic [17:0] o_counter
);
  logic page_mode_ff;
  logic [17:0] index_value_register_ff;
  logic [17:0] counter_ff;
  logic [17:0] rdata_ff;
  logic [17:0] nxt_rdata;

  ////////////////////////////////////////////////////////////////////////////
  // control: page versus bank mode
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      page_mode_ff <= ea_gen_pkg::CTRL_PAGE_RST;
    end else if (i_reg_wr && i_reg_addr == ea_gen_pkg::OFS_CONTROL) begin
      page_mode_ff <= i_reg_wdata[ea_gen_pkg::CTRL_PAGE_BIT];
    end
  end

  // full 18-bit index, sign in the top bit
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      index_value_register_ff <= ea_gen_pkg::INDEX_RST;
    end else if (i_reg_wr && i_reg_addr == ea_gen_pkg::OFS_INDEX) begin
      index_value_register_ff <= i_reg_wdata; // RULE_07
    end
  end

  // 18-bit program counter as seen by the generator
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      counter_ff <= ea_gen_pkg::COUNTER_RST;
    end else if (i_reg_wr && i_reg_addr == ea_gen_pkg::OFS_COUNTER) begin
      counter_ff <= i_reg_wdata; // RULE_07
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read mux; unmapped offsets read zero
  always_comb begin
    nxt_rdata = 18'h00000;
    unique case (i_reg_addr)
      ea_gen_pkg::OFS_CONTROL: nxt_rdata = {17'h00000, page_mode_ff};
      ea_gen_pkg::OFS_INDEX: nxt_rdata = index_value_register_ff;
      ea_gen_pkg::OFS_COUNTER: nxt_rdata = counter_ff;
      ea_gen_pkg::OFS_EFFECTIVE: nxt_rdata = {1'b0, i_effective_address};
      ea_gen_pkg::OFS_STATUS: nxt_rdata = {14'h0000, i_addr_type, i_busy};
      default: nxt_rdata = 18'h00000;
    endcase
  end

  // read data hold only for the cycle after the strobe
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      rdata_ff <= 18'h00000;
    end else begin
      rdata_ff <= i_reg_rd ? nxt_rdata : 18'h00000;
    end
  end

  assign o_reg_rdata = rdata_ff;
  assign o_page_mode = page_mode_ff;
  assign o_index_value = index_value_register_ff;
  assign o_counter = counter_ff;
endmodule : ea_gen_regs

// >>> testbench/mem_model.sv
// behavioural memory behind the mapping unit, answering with a set delay
`timescale 1ns/1ns
module mem_model (
  input wire logic i_clock,
  input wire logic i_srst,
  input wire logic i_mem_req,
  input wire logic i_mem_we,
  input wire logic [16:0] i_mem_addr,
  input wire logic [17:0] i_mem_wdata,
  input wire logic [3:0] i_delay,
  output logic o_mem_ack,
  output logic [17:0] o_mem_rdata
);
  logic [17:0] cells [logic [16:0]];
  logic [3:0] wait_ff;
  int reads = 0;
  int writes = 0;
  ////////////////////////////////////////////////////////////
  // one ack pulse per request; read data is inverted in the cycle after every ack, reads and writes alike
  // so a design that samples it late sees garbage, not a stale match
  always @(posedge i_clock) begin
    if (i_srst) begin
      o_mem_ack <= 1'b0;
      o_mem_rdata <= 18'h2AAAA;
      wait_ff <= 4'h0;
    end else if (o_mem_ack) begin
      o_mem_ack <= 1'b0;
      o_mem_rdata <= ~o_mem_rdata;
    end else if (i_mem_req && wait_ff >= i_delay) begin
      o_mem_ack <= 1'b1;
      wait_ff <= 4'h0;
      if (i_mem_we) begin
        cells[i_mem_addr] = i_mem_wdata;
        writes++;
      end else begin
        o_mem_rdata <= cells.exists(i_mem_addr) ? cells[i_mem_addr] : {1'b0, i_mem_addr} ^ 18'h15A5A;
        reads++;
      end
    end else if (i_mem_req) begin
      wait_ff <= wait_ff + 4'h1;
    end
  end
endmodule : mem_model

// >>> testbench/tb.sv
// self-checking bench of the effective address generator
`timescale 1ns/1ns
`define CHK(nm, exp, got) begin compares++; if ((got) !== (exp)) begin num_errors++; $display("ERROR %s expected %h seen %h", nm, exp, got); end end
module tb;
  logic i_clock = 1'b0;
  logic i_srst = 1'b1;
  logic [7:0] i_reg_addr = 8'h00;
  logic [17:0] i_reg_wdata = 18'h00000;
  logic i_reg_wr = 1'b0;
  logic i_reg_rd = 1'b0;
  logic i_start = 1'b0;
  logic [17:0] i_instruction = 18'h00000;
  logic [17:0] o_reg_rdata, o_mem_wdata, i_mem_rdata;
  logic o_busy, o_done, o_mem_req, o_mem_we, i_mem_ack;
  logic [16:0] o_effective_address, o_mem_addr;
  logic [2:0] o_addr_type;
  logic [3:0] delay = 4'h0;
  logic [31:0] seed = 32'h00009D15;
  int num_errors = 0;
  int compares = 0;
  int cycle_count = 0;
  // worked cases: instruction, page mode, index, counter, pointer word, address
  logic [17:0] c_ins [10] = '{18'h10492, 18'h12249, 18'h12008, 18'h11080, 18'h07040, 18'h0700D, 18'h10008,
    18'h11080, 18'h10FFF, 18'h11001};
  logic [9:0] c_pg = 10'h338;
  logic [17:0] c_xr [10] = '{0, 0, 0, 18'h2F180, 18'h00040, 18'h00200, 0, 0, 0, 18'h3FFFF};
  logic [17:0] c_ctr [10] = '{18'h00040, 18'h00080, 18'h04100, 18'h11600, 18'h10600, 18'h11600, 0, 0, 18'h1F000, 0};
  logic [17:0] c_val [10] = '{0, 18'h070C0, 18'h001FF, 0, 18'h00E00, 18'h001FF, 18'h01234, 0, 0, 0};
  logic [16:0] c_ea [10] = '{17'h00492, 17'h070C0, 17'h00200, 17'h00200, 17'h00E40, 17'h00400, 17'h00008,
    17'h01080, 17'h1FFFF, 17'h00000};
  ////////////////////////////////////////////////////////////
  effective_address_generator uut (.i_clock, .i_srst, .i_reg_addr, .i_reg_wdata, .i_reg_wr, .i_reg_rd,
    .o_reg_rdata, .i_start, .i_instruction, .o_busy, .o_done, .o_effective_address, .o_addr_type,
    .o_mem_req, .o_mem_we, .o_mem_addr, .o_mem_wdata, .i_mem_ack, .i_mem_rdata);
  mem_model mem (.i_clock, .i_srst, .i_mem_req(o_mem_req), .i_mem_we(o_mem_we), .i_mem_addr(o_mem_addr),
    .i_mem_wdata(o_mem_wdata), .i_delay(delay), .o_mem_ack(i_mem_ack), .o_mem_rdata(i_mem_rdata));
  // clock and a hang guard well above the expected run length
  always #4 i_clock = ~i_clock;
  always @(posedge i_clock) begin
    cycle_count <= cycle_count + 1;
    if (cycle_count == 60000) begin
      num_errors++;
      complete_run();
    end
  end
  ////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    for (int i = 0; i < 32; i++) s = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    return s;
  endfunction : lfsr
  // reference model of address formation
  function automatic void expect_ea(input logic [17:0] ins, input logic pg, input logic [17:0] xr,
    input logic [17:0] ctr, input logic [17:0] val, output logic [16:0] ea, output logic [2:0] ty,
    output logic [16:0] ptr, output logic [17:0] wb);
    logic ind, x, au;
    logic [16:0] fld, base;
    ind = ins[13];
    x = pg & ins[12];
    fld = pg ? {ctr[16:12], ins[11:0]} : {ctr[16:13], ins[12:0]};
    au = ind && (pg ? ins[11:0] inside {[8:15]} : ins[12:0] inside {[8:15]});
    ptr = au ? (pg ? 17'(ins[11:0]) : 17'(ins[12:0])) : fld;
    wb = au ? val + 18'h00001 : val;
    base = ind ? wb[16:0] : fld;
    ea = x ? base + xr[16:0] : base;
    ty = !ind ? (x ? ea_gen_pkg::TYPE_INDEXED : ea_gen_pkg::TYPE_DIRECT) : au ?
      (x ? ea_gen_pkg::TYPE_AUTO_INDEXED : ea_gen_pkg::TYPE_AUTO) :
      (x ? ea_gen_pkg::TYPE_IND_INDEXED : ea_gen_pkg::TYPE_INDIRECT);
  endfunction : expect_ea
  task automatic reg_wr(input logic [7:0] a, input logic [17:0] d);
    @(posedge i_clock);
    i_reg_addr <= a;
    i_reg_wdata <= d;
    i_reg_wr <= 1'b1;
    @(posedge i_clock);
    i_reg_wr <= 1'b0;
  endtask : reg_wr
  task automatic reg_rd(input logic [7:0] a, input logic [17:0] e, input string nm);
    @(posedge i_clock);
    i_reg_addr <= a;
    i_reg_rd <= 1'b1;
    @(posedge i_clock);
    i_reg_rd <= 1'b0;
    #1;
    `CHK(nm, e, o_reg_rdata)
  endtask : reg_rd
  // one reference: set up, start, refuse a second start while busy, check all effects
  task automatic run_one(input logic [17:0] ins, input logic pg, input logic [17:0] xr, input logic [17:0] ctr,
    input logic [17:0] val, input logic [3:0] dly);
    logic [16:0] ea, ptr;
    logic [2:0] ty;
    logic [17:0] wb;
    int n, cyc;
    expect_ea(ins, pg, xr, ctr, val, ea, ty, ptr, wb);
    cyc = (ins[13] ? 2 : 0) + ((ty == ea_gen_pkg::TYPE_AUTO || ty == ea_gen_pkg::TYPE_AUTO_INDEXED) ? 1 : 0);
    reg_wr(ea_gen_pkg::OFS_CONTROL, {17'h00000, pg});
    reg_wr(ea_gen_pkg::OFS_INDEX, xr);
    reg_wr(ea_gen_pkg::OFS_COUNTER, ctr);
    mem.cells[ptr] = val;
    mem.reads = 0;
    mem.writes = 0;
    @(posedge i_clock);
    delay <= dly;
    i_start <= 1'b1;
    i_instruction <= ins;
    if (ins[13]) begin
      @(posedge i_clock);
      i_instruction <= ~ins;
    end
    @(posedge i_clock);
    i_start <= 1'b0;
    n = 1;
    #1;
    `CHK("busy", ins[13], o_busy)
    while (o_done !== 1'b1 && n < 300) begin
      @(posedge i_clock);
      #1;
      n++;
    end
    `CHK("done", 1'b1, o_done)
    `CHK("effective address", ea, o_effective_address)
    `CHK("type", ty, o_addr_type)
    `CHK("memory cycles", cyc, 2 * mem.reads + mem.writes)
    `CHK("pointer cell", wb, mem.cells[ptr])
    if (!ins[13]) `CHK("latency", 1, n)
    reg_rd(ea_gen_pkg::OFS_EFFECTIVE, {1'b0, ea}, "effective register");
    reg_rd(ea_gen_pkg::OFS_STATUS, {15'h0000, ty} << 1, "status register");
  endtask : run_one
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : complete_run
  ////////////////////////////////////////////////////////////
  initial begin
    logic [17:0] ins;
    logic [31:0] s1, s2;
    repeat (8) @(posedge i_clock);
    i_srst <= 1'b0;
    // reset values, including the unmapped offset after the map
    for (int i = 0; i < 6; i++) reg_rd(8'(4 * i), 18'h00000, "reset value");
    reg_wr(ea_gen_pkg::OFS_EFFECTIVE, 18'h3FFFF);
    reg_wr(8'h14, 18'h3FFFF);
    reg_rd(ea_gen_pkg::OFS_EFFECTIVE, 18'h00000, "read-only effective");
    reg_rd(8'h14, 18'h00000, "unmapped");
    reg_wr(ea_gen_pkg::OFS_INDEX, 18'h3FFFF);
    reg_rd(ea_gen_pkg::OFS_INDEX, 18'h3FFFF, "index width");
    reg_wr(ea_gen_pkg::OFS_COUNTER, 18'h3FFFF);
    reg_rd(ea_gen_pkg::OFS_COUNTER, 18'h3FFFF, "counter width");
    // worked cases of all six types, bank and page, top and bottom addresses
    for (int i = 0; i < 10; i++) begin
      run_one(c_ins[i], c_pg[i], c_xr[i], c_ctr[i], c_val[i], 4'(i));
      `CHK("worked case", c_ea[i], o_effective_address)
    end
    // random references, a quarter steered onto the auto-increment cells
    for (int k = 0; k < 250; k++) begin
      seed = lfsr(seed);
      ins = seed[17:0];
      if (seed[20:19] == 2'b00) ins[11:0] = 12'h008 | 12'(seed[23:21]);
      s1 = lfsr(seed);
      s2 = lfsr(s1);
      run_one(ins, seed[24], s1[17:0], s2[17:0], seed[31:14], seed[28:25]);
    end
    // reset in the middle of an indirect reference clears every register and request
    @(posedge i_clock);
    i_start <= 1'b1;
    i_instruction <= 18'h02000;
    @(posedge i_clock);
    i_start <= 1'b0;
    i_srst <= 1'b1;
    repeat (2) @(posedge i_clock);
    i_srst <= 1'b0;
    for (int i = 0; i < 5; i++) reg_rd(8'(4 * i), 18'h00000, "reset again");
    `CHK("request after reset", 1'b0, o_mem_req)
    complete_run();
  end
endmodule : tb
